// file: ssc_stats.sv
/*
  Statistics counters of one channel: transmit size bins, valid receive bytes, error
  runt and jabber, pause counters, cleared-since-read flags, and the seven sideband
  control counters returned by the statistics query. Registers sit on AHB-Lite.
  Assumes frame and sideband events come from logic on hclk as one-cycle pulses.
*/
// Contract
// - count good tx frames in five size bins
// - count tx frames over 1523 bytes passing filter
// - add bytes of every error-free rx packet
// - count invalid rx frames under 64 bytes
// - count rx over mtu with bad fcs
// - flag counters cleared elsewhere since sideband read
// - cleared counters restart from zero
// - flags as lower word and upper word
// - pfc frames optionally counted in pause counters
// - statistics query uses command code 0x19
// - reply type 0x99 with seven counter words
// - process query and reply, no reason code
// - sideband counters clear on init and read
// - unimplemented sideband counters read all ones
// - counters saturate at all ones
// - count commands received and not dropped
// - count dropped packets, bad channel optional
// - count unsupported commands
// - count checksum drops
// - receive total is commands plus drops
// - transmit total is responses plus aens
// - count aens sent
`timescale 1ns/1ps
`default_nettype none
`include "ssc_defs.svh"
module ssc_stats
  import ssc_pkg::*;
#(
  parameter logic [6:0] SB_IMPL = 7'h7f,
  parameter bit EXCL_BAD_CHAN = 1'b1,
  parameter int NLAN = 13
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // mac frame events
  input wire ssc_frame_t tx_frame,
  input wire ssc_frame_t rx_frame,
  input wire logic [3:0] pause_ev,
  input wire logic [3:0] pfc_ev,
  input wire logic [38:0] lan_host_clr,
  // sideband events and channel state
  input wire ssc_sb_ev_t sb_ev,
  input wire logic init_enter,
  // status
  output logic rsp_ready
);
  // saturating add, shared by every counter
  function automatic logic [31:0] sat_add(input logic [31:0] a, input logic [31:0] b);
    logic [32:0] s;
    s = {1'b0, a} + {1'b0, b};
    return s[32] ? `SSC_CNT_MAX : s[31:0];
  endfunction : sat_add

  // bin membership, inclusive bounds
  function automatic logic in_bin(input logic [13:0] l, input logic [13:0] lo,
                                  input logic [13:0] hi);
    return (l >= lo) && (l <= hi);
  endfunction : in_bin

  logic [31:0] lan_reg [0:NLAN-1];
  logic [31:0] sb_reg [0:6];
  logic [31:0] rsp_reg [0:6];
  logic [38:0] flag_reg;
  logic [13:0] mtu_reg;
  logic pfc_en_reg;
  logic [7:0] rsp_type_reg;
  logic [15:0] rsp_code_reg;
  logic [15:0] rsn_code_reg;
  logic rsp_valid_reg;
  logic [31:0] hrdata_reg;
  logic [7:0] wr_addr_reg;
  logic wr_pend_reg;

  // ahb decode: reads in the address phase, command writes in the data phase
  wire logic acc = hsel && htrans[1] && hready;
  wire logic rd_acc = acc && !hwrite;
  wire logic wr_acc = acc && hwrite;
  wire logic rd_flag_lo = rd_acc && (haddr == `SSC_OFS_FLAG_LO);
  wire logic rd_flag_hi = rd_acc && (haddr == `SSC_OFS_FLAG_HI);
  wire logic wr_cmd = wr_pend_reg && (wr_addr_reg == `SSC_OFS_CMD);
  wire logic query = wr_cmd && (hwdata[7:0] == `SSC_CMD_GET_STATS);
  wire logic unsup = wr_cmd && !query;

  // transmit bins: 65-127 .. 1024-1522, then oversize
  wire logic tx_ok = tx_frame.done && tx_frame.good;
  wire logic [13:0] tl = tx_frame.len;
  wire logic [5:0] tx_bin;
  assign tx_bin[0] = tx_ok && in_bin(tl, `SSC_LEN_B0_LO, `SSC_LEN_B1_LO - 14'h0001);
  assign tx_bin[1] = tx_ok && in_bin(tl, `SSC_LEN_B1_LO, `SSC_LEN_B2_LO - 14'h0001);
  assign tx_bin[2] = tx_ok && in_bin(tl, `SSC_LEN_B2_LO, `SSC_LEN_B3_LO - 14'h0001);
  assign tx_bin[3] = tx_ok && in_bin(tl, `SSC_LEN_B3_LO, `SSC_LEN_B4_LO - 14'h0001);
  assign tx_bin[4] = tx_ok && in_bin(tl, `SSC_LEN_B4_LO, `SSC_LEN_B4_HI);
  assign tx_bin[5] = tx_frame.done && tx_frame.addr_pass && (tl > `SSC_LEN_OVER);

  // receive error classes
  wire logic rx_clean = rx_frame.done && rx_frame.good && !rx_frame.fcs_bad;
  wire logic rx_runt = rx_frame.done && !rx_frame.good && (rx_frame.len < `SSC_LEN_MIN);
  wire logic rx_jab = rx_frame.done && rx_frame.fcs_bad && (rx_frame.len > mtu_reg);

  // pause counters, pfc folded in when enabled
  wire logic [3:0] pause_inc = pause_ev | (pfc_ev & {4{pfc_en_reg}});

  // per-slot increment and clear of the lan array
  logic [31:0] lan_add [0:NLAN-1];
  logic [NLAN-1:0] lan_clr;
  always_comb begin
    for (int i = 0; i < NLAN; i++) begin
      lan_add[i] = 32'h00000000;
      lan_clr[i] = 1'b0;
    end
    for (int i = 0; i < 6; i++) begin
      lan_add[i] = {31'h00000000, tx_bin[i]};
      lan_clr[i] = lan_host_clr[`SSC_LAN_FIRST + i];
    end
    lan_add[6] = rx_clean ? {18'h00000, rx_frame.len} : 32'h00000000;
    lan_add[7] = {31'h00000000, rx_runt};
    lan_add[8] = {31'h00000000, rx_jab};
    for (int i = 6; i < 9; i++) begin
      lan_clr[i] = lan_host_clr[`SSC_LAN_FIRST + i];
    end
    for (int i = 0; i < 4; i++) begin
      lan_add[9 + i] = {31'h00000000, pause_inc[i]};
      lan_clr[9 + i] = lan_host_clr[`SSC_PAUSE_FIRST + i];
    end
  end

  // lan counters; a clear restarts at zero but keeps a same-cycle event
  always_ff @(posedge hclk or negedge hresetn) begin
    for (int i = 0; i < NLAN; i++) begin
      if (!hresetn) begin
        lan_reg[i] <= 32'h00000000;
      end else if (lan_clr[i]) begin
        lan_reg[i] <= lan_add[i];
      end else begin
        lan_reg[i] <= sat_add(lan_reg[i], lan_add[i]);
      end
    end
  end

  // cleared-since-read flags; a new clear beats the read that empties them
  wire logic [38:0] flag_rd_clr = {{`SSC_HI_FLAG_BITS{rd_flag_hi}}, {32{rd_flag_lo}}};
  wire logic [38:0] flag_next = (flag_reg & ~flag_rd_clr) | lan_host_clr;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flag_reg <= 39'h0000000000;
    end else begin
      flag_reg <= flag_next;
    end
  end

  // sideband increments; the block's own query counts as command and response
  wire logic drop_cnt = sb_ev.pkt_drop && !(EXCL_BAD_CHAN && sb_ev.drop_bad_chan);
  wire logic cmd_cnt = sb_ev.cmd_rcvd || wr_cmd;
  wire logic rsp_cnt = sb_ev.rsp_sent || wr_cmd;
  logic [31:0] sb_add [0:6];
  always_comb begin
    sb_add[0] = {31'h00000000, cmd_cnt};
    sb_add[1] = {31'h00000000, drop_cnt};
    sb_add[2] = {31'h00000000, sb_ev.cmd_unsup || unsup};
    sb_add[3] = {31'h00000000, sb_ev.cksum_err};
    sb_add[4] = {30'h00000000, 2'(cmd_cnt) + 2'(drop_cnt)};
    sb_add[5] = {30'h00000000, 2'(rsp_cnt) + 2'(sb_ev.aen_sent)};
    sb_add[6] = {31'h00000000, sb_ev.aen_sent};
  end

  // sideband counters: cleared on init and when the query reads them
  always_ff @(posedge hclk or negedge hresetn) begin
    for (int i = 0; i < 7; i++) begin
      if (!hresetn) begin
        sb_reg[i] <= 32'h00000000;
      end else if (init_enter) begin
        sb_reg[i] <= 32'h00000000;
      end else if (query) begin
        sb_reg[i] <= sb_add[i];
      end else begin
        sb_reg[i] <= sat_add(sb_reg[i], sb_add[i]);
      end
    end
  end

  // response words captured at the query, all ones where not implemented
  always_ff @(posedge hclk or negedge hresetn) begin
    for (int i = 0; i < 7; i++) begin
      if (!hresetn) begin
        rsp_reg[i] <= 32'h00000000;
      end else if (query) begin
        rsp_reg[i] <= SB_IMPL[i] ? sb_reg[i] : `SSC_CNT_MAX;
      end
    end
  end

  // response header and completion codes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rsp_type_reg <= 8'h00;
      rsp_code_reg <= `SSC_RSP_OK;
      rsn_code_reg <= `SSC_RSN_NONE;
      rsp_valid_reg <= 1'b0;
    end else if (wr_cmd) begin
      rsp_type_reg <= query ? `SSC_RSP_GET_STATS : (hwdata[7:0] | 8'h80);
      rsp_code_reg <= query ? `SSC_RSP_OK : `SSC_RSP_UNSUP;
      rsn_code_reg <= query ? `SSC_RSN_NONE : `SSC_RSN_UNSUP;
      rsp_valid_reg <= 1'b1;
    end
  end

  // software control: pfc option and mtu
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pfc_en_reg <= 1'b0;
      mtu_reg <= `SSC_MTU_RST;
    end else if (wr_pend_reg && wr_addr_reg == `SSC_OFS_CTRL) begin
      pfc_en_reg <= hwdata[`SSC_CTRL_PFC_BIT];
    end else if (wr_pend_reg && wr_addr_reg == `SSC_OFS_MTU) begin
      mtu_reg <= hwdata[13:0];
    end
  end

  // read mux on the address phase
  wire logic [7:0] ra = haddr - `SSC_OFS_RSP_BASE;
  wire logic [7:0] la = haddr - `SSC_OFS_LAN_BASE;
  wire logic rsp_hit = (haddr >= `SSC_OFS_RSP_BASE) && (ra[7:2] < 6'd7) && (ra[1:0] == 2'b00);
  wire logic lan_hit = (haddr >= `SSC_OFS_LAN_BASE) && (la[7:2] < 6'(NLAN)) &&
                       (la[1:0] == 2'b00);
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h00000000;
    if (rsp_hit) begin
      rd_mux = rsp_reg[ra[4:2]];
    end else if (lan_hit) begin
      rd_mux = lan_reg[la[5:2]];
    end else begin
      unique case (haddr)
        `SSC_OFS_CTRL: rd_mux = {31'h00000000, pfc_en_reg};
        `SSC_OFS_MTU: rd_mux = {18'h00000, mtu_reg};
        `SSC_OFS_RSP_HDR: rd_mux = {23'h000000, rsp_valid_reg, rsp_type_reg};
        `SSC_OFS_RSP_CODE: rd_mux = {rsp_code_reg, rsn_code_reg};
        `SSC_OFS_FLAG_LO: rd_mux = flag_reg[31:0];
        `SSC_OFS_FLAG_HI: rd_mux = {25'h0000000, flag_reg[38:32]};
        default: rd_mux = 32'h00000000;
      endcase
    end
  end

  // bus pipeline: read data out for the data phase, write captured for it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_reg <= 32'h00000000;
      wr_addr_reg <= 8'h00;
      wr_pend_reg <= 1'b0;
    end else begin
      hrdata_reg <= rd_acc ? rd_mux : 32'h00000000;
      wr_addr_reg <= haddr;
      wr_pend_reg <= wr_acc;
    end
  end

  // outputs, all from flops
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end
  assign hrdata = hrdata_reg;
  assign rsp_ready = rsp_valid_reg;

  // checks
  chk_tx_bin_small: assert property (@(posedge hclk) disable iff (!hresetn)
    tx_ok && tl == `SSC_LEN_B0_LO && !lan_clr[0] && lan_reg[0] != `SSC_CNT_MAX
    |=> lan_reg[0] == $past(lan_reg[0]) + 32'h00000001)
    else $error("65-127 tx bin did not step");
  chk_tx_oversize: assert property (@(posedge hclk) disable iff (!hresetn)
    tx_frame.done && tl == `SSC_LEN_OVER |=> lan_reg[5] == $past(lan_reg[5]) ||
    $past(lan_clr[5]))
    else $error("1523-byte frame counted as oversize");
  chk_rx_valid_bytes: assert property (@(posedge hclk) disable iff (!hresetn)
    rx_clean && !lan_clr[6] && lan_reg[6] < 32'h80000000
    |=> lan_reg[6] == $past(lan_reg[6]) + {18'h00000, $past(rx_frame.len)})
    else $error("valid byte count wrong");
  chk_rx_runt: assert property (@(posedge hclk) disable iff (!hresetn)
    rx_frame.done && !rx_frame.good && rx_frame.len == 14'h003f && !lan_clr[7] &&
    lan_reg[7] != `SSC_CNT_MAX |=> lan_reg[7] == $past(lan_reg[7]) + 32'h00000001)
    else $error("runt not counted");
  chk_rx_jabber: assert property (@(posedge hclk) disable iff (!hresetn)
    rx_frame.done && !rx_frame.fcs_bad |=> lan_reg[8] == $past(lan_reg[8]) ||
    $past(lan_clr[8]))
    else $error("jabber counted without bad fcs");
  chk_flag_set: assert property (@(posedge hclk) disable iff (!hresetn)
    lan_host_clr[3] |=> flag_reg[3] ##1 (flag_reg[3] || $past(rd_flag_lo)))
    else $error("cleared flag lost");
  chk_lan_restart: assert property (@(posedge hclk) disable iff (!hresetn)
    lan_clr[6] && !rx_clean |=> lan_reg[6] == 32'h00000000)
    else $error("lan counter not restarted at zero");
  chk_sb_init: assert property (@(posedge hclk) disable iff (!hresetn)
    init_enter |=> sb_reg[0] == 32'h00000000 && sb_reg[4] == 32'h00000000)
    else $error("sideband counters survive init");
  chk_rsp_type: assert property (@(posedge hclk) disable iff (!hresetn)
    query |=> rsp_type_reg == `SSC_RSP_GET_STATS && rsp_code_reg == `SSC_RSP_OK &&
    rsp_reg[0] == (SB_IMPL[0] ? $past(sb_reg[0]) : `SSC_CNT_MAX))
    else $error("statistics reply wrong");
  chk_sb_saturate: assert property (@(posedge hclk) disable iff (!hresetn)
    sb_reg[6] == `SSC_CNT_MAX && !init_enter && !query |=> sb_reg[6] == `SSC_CNT_MAX)
    else $error("aen counter wrapped");
  chk_rx_total: assert property (@(posedge hclk) disable iff (!hresetn)
    !init_enter && !query && sb_reg[4] < 32'h80000000
    |=> sb_reg[4] == $past(sb_reg[4]) + $past(sb_add[0]) + $past(sb_add[1]))
    else $error("receive total not commands plus drops");

  // flag, pause option and sideband counter checks
  chk_flag_read_clr: assert property (@(posedge hclk) disable iff (!hresetn)
    rd_flag_lo && lan_host_clr[31:0] == 32'h00000000 |=> flag_reg[31:0] == 32'h00000000)
    else $error("lower flag word not emptied by read");
  chk_pfc_ignored: assert property (@(posedge hclk) disable iff (!hresetn)
    !pfc_en_reg && pfc_ev[0] && !pause_ev[0] && !lan_clr[9]
    |=> lan_reg[9] == $past(lan_reg[9]))
    else $error("pfc frame counted while disabled");
  chk_sb_query_clr: assert property (@(posedge hclk) disable iff (!hresetn)
    query && !init_enter |=> sb_reg[3] == $past(sb_add[3]))
    else $error("checksum counter not cleared by query");
  chk_rsp_unimpl: assert property (@(posedge hclk) disable iff (!hresetn)
    query && !SB_IMPL[6] |=> rsp_reg[6] == `SSC_CNT_MAX)
    else $error("unimplemented counter not all ones");
  chk_cmd_count: assert property (@(posedge hclk) disable iff (!hresetn)
    sb_ev.cmd_rcvd && !init_enter && !query && sb_reg[0] != `SSC_CNT_MAX
    |=> sb_reg[0] == $past(sb_reg[0]) + 32'h00000001)
    else $error("command not counted");
  chk_drop_bad_chan: assert property (@(posedge hclk) disable iff (!hresetn)
    EXCL_BAD_CHAN && sb_ev.pkt_drop && sb_ev.drop_bad_chan && !init_enter && !query
    |=> sb_reg[1] == $past(sb_reg[1]))
    else $error("bad channel drop counted");
  chk_unsup_count: assert property (@(posedge hclk) disable iff (!hresetn)
    unsup && !init_enter && sb_reg[2] != `SSC_CNT_MAX
    |=> sb_reg[2] == $past(sb_reg[2]) + 32'h00000001)
    else $error("unsupported command not counted");
  chk_cksum_count: assert property (@(posedge hclk) disable iff (!hresetn)
    sb_ev.cksum_err && !init_enter && !query && sb_reg[3] != `SSC_CNT_MAX
    |=> sb_reg[3] == $past(sb_reg[3]) + 32'h00000001)
    else $error("checksum drop not counted");
  chk_tx_total: assert property (@(posedge hclk) disable iff (!hresetn)
    sb_ev.aen_sent && !sb_ev.rsp_sent && !wr_cmd && !init_enter &&
    sb_reg[5] != `SSC_CNT_MAX |=> sb_reg[5] == $past(sb_reg[5]) + 32'h00000001)
    else $error("aen missing from transmit total");
  chk_aen_count: assert property (@(posedge hclk) disable iff (!hresetn)
    sb_ev.aen_sent && !init_enter && !query && sb_reg[6] != `SSC_CNT_MAX
    |=> sb_reg[6] == $past(sb_reg[6]) + 32'h00000001)
    else $error("aen not counted");
endmodule : ssc_stats
`default_nettype wire

// file: ssc_defs.svh
/*
  Offsets, field positions, reset values, frame-size limits and codes of the sideband
  statistics block. Assumes inclusion by bare name from the package and the design.
*/
`ifndef SSC_DEFS_SVH
`define SSC_DEFS_SVH
// register byte offsets
`define SSC_OFS_CTRL 8'h00
`define SSC_OFS_MTU 8'h04
`define SSC_OFS_CMD 8'h08
`define SSC_OFS_RSP_HDR 8'h0c
`define SSC_OFS_RSP_CODE 8'h10
`define SSC_OFS_RSP_BASE 8'h20
`define SSC_OFS_FLAG_LO 8'h40
`define SSC_OFS_FLAG_HI 8'h44
`define SSC_OFS_LAN_BASE 8'h80
// field positions and reset values
`define SSC_CTRL_PFC_BIT 0
`define SSC_HDR_VALID_BIT 8
`define SSC_MTU_RST 14'h05dc
`define SSC_HI_FLAG_BITS 7
// frame-size bin limits, destination address through fcs
`define SSC_LEN_MIN 14'h0040
`define SSC_LEN_B0_LO 14'h0041
`define SSC_LEN_B1_LO 14'h0080
`define SSC_LEN_B2_LO 14'h0100
`define SSC_LEN_B3_LO 14'h0200
`define SSC_LEN_B4_LO 14'h0400
`define SSC_LEN_B4_HI 14'h05f2
`define SSC_LEN_OVER 14'h05f3
// sideband command and response codes
`define SSC_CMD_GET_STATS 8'h19
`define SSC_RSP_GET_STATS 8'h99
`define SSC_RSP_OK 16'h0000
`define SSC_RSP_UNSUP 16'h0001
`define SSC_RSN_NONE 16'h0000
`define SSC_RSN_UNSUP 16'h7fff
`define SSC_CNT_MAX 32'hffffffff
`define SSC_LAN_FIRST 30
`define SSC_PAUSE_FIRST 13
`endif

// file: ssc_pkg.sv
/*
  Types shared by the sideband statistics block: event carriers from the MAC and
  from the sideband front end. Assumes ssc_defs.svh is on the include path.
*/
package ssc_pkg;
  `include "ssc_defs.svh"
  // one finished frame, transmit or receive
  typedef struct packed {
    logic done;
    logic good;
    logic addr_pass;
    logic fcs_bad;
    logic [13:0] len;
  } ssc_frame_t;
  // sideband control traffic events, one-cycle pulses
  typedef struct packed {
    logic cmd_rcvd;
    logic pkt_drop;
    logic drop_bad_chan;
    logic cmd_unsup;
    logic cksum_err;
    logic rsp_sent;
    logic aen_sent;
  } ssc_sb_ev_t;
endpackage : ssc_pkg

// file: ssc_mc_model.sv
/*
  Management controller stand-in: sends sideband control traffic events toward the
  statistics block. Assumes the bench calls send() from its own sequence on hclk.
*/
`timescale 1ns/1ps
`default_nettype none
module ssc_mc_model
  import ssc_pkg::*;
(
  // clock
  input wire logic hclk,
  // sideband event pulses toward the counters
  output var ssc_sb_ev_t sb_ev
);
  // code of the statistics query
  localparam logic [7:0] QUERY_CODE = 8'h19;
  // idle until the first event
  initial sb_ev = '0;
  // one-cycle pulse, then back to idle zero
  task automatic send(input ssc_sb_ev_t e);
    @(posedge hclk);
    sb_ev <= e;
    @(posedge hclk);
    sb_ev <= '0;
  endtask : send
endmodule : ssc_mc_model
`default_nettype wire

// file: testbench.sv
/*
  Self-checking bench of the statistics block: frame rows, host clears, pause, query.
  Assumes one AHB-Lite slave, hready looped from hreadyout, events on hclk.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import ssc_pkg::*;
  typedef struct packed {logic tx; ssc_frame_t f; logic [3:0] idx; logic [13:0] dlt;} ssc_row_t;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  wire logic hready;
  logic [31:0] hrdata, rd;
  logic hreadyout, hresp, rsp_ready, init_enter = 1'b0;
  ssc_frame_t tx_frame = '0, rx_frame = '0;
  logic [3:0] pause_ev = 4'h0, pfc_ev = 4'h0;
  logic [38:0] lan_host_clr = 39'h0;
  ssc_sb_ev_t sb_ev;
  ssc_row_t rows [16];
  logic [6:0] sbv [6] = '{7'h42, 7'h4a, 7'h20, 7'h30, 7'h24, 7'h01};
  logic [31:0] e2 [7] = '{32'h3, 32'h2, 32'h1, 32'h1, 32'h5, 32'h4, 32'hffffffff};
  logic [31:0] e3 [7] = '{32'h1, 32'h0, 32'h0, 32'h0, 32'h1, 32'h1, 32'hffffffff};
  logic [31:0] e4 [7] = '{32'h2, 32'h0, 32'h1, 32'h0, 32'h2, 32'h2, 32'hffffffff};
  int errors = 0, checks = 0, cyc = 0;
  assign hready = hreadyout;
  // clock, 50 ns period
  always #25 hclk = ~hclk;
  ssc_stats #(.SB_IMPL(7'h3f), .EXCL_BAD_CHAN(1'b1), .NLAN(13)) dut_u (.hclk(hclk),
    .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .tx_frame(tx_frame), .rx_frame(rx_frame), .pause_ev(pause_ev),
    .pfc_ev(pfc_ev), .lan_host_clr(lan_host_clr), .sb_ev(sb_ev), .init_enter(init_enter),
    .rsp_ready(rsp_ready));
  ssc_mc_model mc_u (.hclk(hclk), .sb_ev(sb_ev));
  // verdict and end of run
  task automatic test_done();
    if (errors == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : test_done
  // hang guard
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      $display("MISMATCH at %0t: run too long", $time);
      test_done();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // one single AHB-Lite transfer, waits on hready in both phases
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    q = hrdata;
  endtask : bus
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q, exp);
  endtask : rdc
  // one-cycle event pulse on the mac side
  task automatic pl(input ssc_frame_t t, input ssc_frame_t r, input logic [3:0] pa,
                    input logic [3:0] pf, input logic [38:0] hc, input logic ie);
    @(posedge hclk);
    tx_frame <= t;
    rx_frame <= r;
    pause_ev <= pa;
    pfc_ev <= pf;
    lan_host_clr <= hc;
    init_enter <= ie;
    @(posedge hclk);
    tx_frame <= '0;
    rx_frame <= '0;
    pause_ev <= 4'h0;
    pfc_ev <= 4'h0;
    lan_host_clr <= 39'h0;
    init_enter <= 1'b0;
  endtask : pl
  function automatic ssc_row_t mk(input logic t, input logic [3:0] fl, input logic [13:0] n,
                                  input logic [3:0] i, input logic [13:0] d);
    return {t, 1'b1, fl[2:0], n, i, d};
  endfunction : mk
  function automatic logic [7:0] lan(input logic [3:0] i);
    return 8'h80 + {2'b00, i, 2'b00};
  endfunction : lan
  // query, then read and compare the seven response words
  task automatic qry(input logic [31:0] e [7]);
    bus(1'b1, 8'h08, {24'h0, mc_u.QUERY_CODE}, rd);
    for (int k = 0; k < 7; k++) rdc(8'h20 + 8'(4 * k), e[k]);
  endtask : qry
  // main sequence
  initial begin
    // rows: tx, {good, addr_pass, fcs_bad}, length, counter slot, expected step
    rows[0] = mk(1'b1, 4'h4, 14'h041, 4'h0, 14'h1);
    rows[1] = mk(1'b1, 4'h4, 14'h07f, 4'h0, 14'h1);
    rows[2] = mk(1'b1, 4'h4, 14'h080, 4'h1, 14'h1);
    rows[3] = mk(1'b1, 4'h4, 14'h0ff, 4'h1, 14'h1);
    rows[4] = mk(1'b1, 4'h4, 14'h100, 4'h2, 14'h1);
    rows[5] = mk(1'b1, 4'h4, 14'h1ff, 4'h2, 14'h1);
    rows[6] = mk(1'b1, 4'h4, 14'h200, 4'h3, 14'h1);
    rows[7] = mk(1'b1, 4'h4, 14'h3ff, 4'h3, 14'h1);
    rows[8] = mk(1'b1, 4'h4, 14'h400, 4'h4, 14'h1);
    rows[9] = mk(1'b1, 4'h4, 14'h5f2, 4'h4, 14'h1);
    rows[10] = mk(1'b1, 4'h2, 14'h5f4, 4'h5, 14'h1);
    rows[11] = mk(1'b1, 4'h2, 14'h5f3, 4'h5, 14'h0);
    rows[12] = mk(1'b0, 4'h4, 14'h064, 4'h6, 14'h064);
    rows[13] = mk(1'b0, 4'h0, 14'h03f, 4'h7, 14'h1);
    rows[14] = mk(1'b0, 4'h1, 14'h5dd, 4'h8, 14'h1);
    rows[15] = mk(1'b0, 4'h1, 14'h5dc, 4'h8, 14'h0);
    for (int i = 0; i < 16; i++) rows[i].f.good = rows[i].f.good & (rows[i].idx < 4'h7);
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    // reset values and an unmapped place
    chk({29'h0, rsp_ready, hresp, hreadyout}, 32'h1);
    rdc(8'h04, 32'h000005dc);
    rdc(8'h0c, 32'h0);
    rdc(8'h40, 32'h0);
    rdc(8'h7c, 32'h0);
    for (int i = 0; i < 16; i++) begin
      bus(1'b0, lan(rows[i].idx), 32'h0, rd);
      if (rows[i].tx) pl(rows[i].f, '0, 4'h0, 4'h0, 39'h0, 1'b0);
      else pl('0, rows[i].f, 4'h0, 4'h0, 39'h0, 1'b0);
      rdc(lan(rows[i].idx), rd + {18'h0, rows[i].dlt});
    end
    // host clears of counters 3, 36 and 38
    pl('0, '0, 4'h0, 4'h0, 39'h50_0000_0008, 1'b0);
    rdc(8'h40, 32'h8);
    rdc(8'h44, 32'h50);
    rdc(8'h40, 32'h0);
    rdc(8'h44, 32'h0);
    rdc(lan(4'h6), 32'h0);
    rdc(lan(4'h8), 32'h0);
    pl('0, {4'hc, 14'h064}, 4'h0, 4'h0, 39'h0, 1'b0);
    rdc(lan(4'h6), 32'h64);
    // pause counters, pfc counted only once enabled
    for (int p = 0; p < 2; p++) begin
      bus(1'b1, 8'h00, 32'(p), rd);
      for (int k = 0; k < 4; k++) begin
        bus(1'b0, lan(4'(9 + k)), 32'h0, rd);
        pl('0, '0, 4'(1 << k), 4'h0, 39'h0, 1'b0);
        pl('0, '0, 4'h0, 4'(1 << k), 39'h0, 1'b0);
        rdc(lan(4'(9 + k)), rd + 32'h1 + 32'(p));
      end
    end
    // traffic before the initial state is forgotten
    mc_u.send(7'h21);
    pl('0, '0, 4'h0, 4'h0, 39'h0, 1'b1);
    bus(1'b1, 8'h08, {24'h0, mc_u.QUERY_CODE}, rd);
    rdc(8'h24, 32'h0);
    chk({31'h0, rsp_ready}, 32'h1);
    rdc(8'h0c, 32'h199);
    rdc(8'h10, 32'h0);
    for (int k = 0; k < 6; k++) mc_u.send(sbv[k]);
    qry(e2);
    qry(e3);
    // unsupported code, mtu write, then a reset in mid-run
    bus(1'b1, 8'h08, 32'h05, rd);
    rdc(8'h0c, 32'h185);
    rdc(8'h10, 32'h00017fff);
    qry(e4);
    bus(1'b1, 8'h04, 32'h0200, rd);
    rdc(8'h04, 32'h0200);
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    chk({29'h0, rsp_ready, hresp, hreadyout}, 32'h1);
    rdc(8'h04, 32'h000005dc);
    rdc(8'h0c, 32'h0);
    test_done();
  end
endmodule : testbench
`default_nettype wire
